// *** rtl/mbra_defines.svh ***
// Purpose: Constants for byte access to multi-byte register fields
// Assumes: Byte-wide write port from a serial front end on core_clk
// Notes: Little-endian field layout
`ifndef MBRA_DEFINES_SVH
`define MBRA_DEFINES_SVH
`define MBRA_ADDR_W 8
`define MBRA_BLOCK_BASE 8'h10
`define MBRA_BLOCK_STRIDE 8'h08
`define MBRA_BLOCK_COUNT 2
`define MBRA_FIELD_BYTES 4
`define MBRA_ATOMIC_OFS 8'h00
`define MBRA_PLAIN_OFS 8'h04
`define MBRA_RESET_VALUE 32'h0000_0000
`endif

// *** rtl/mbra_pkg.sv ***
// Purpose: Types for byte access to multi-byte register fields
// Assumes: Constants come from mbra_defines.svh
// Notes: None
package mbra_pkg;
   typedef struct packed
   {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } byte_wr_t;
   typedef struct packed
   {
      logic hit;
      logic [0:0] inst;
      logic atomic;
      logic [1:0] lane;
   } decode_t;
endpackage

// *** rtl/field_byte_merge.sv ***
// Purpose: Writes one byte lane into a multi-byte value
// Assumes: Lane within the field width
// Notes: Combinational
`timescale 1ns/10ps
`include "mbra_defines.svh"
module field_byte_merge
#(
   parameter int BYTES = `MBRA_FIELD_BYTES
)
(
   input wire logic [8*BYTES-1:0] oldValue,
   input wire logic [1:0] lane,
   input wire logic [7:0] data,
   output logic [8*BYTES-1:0] newValue
);
   always_comb
   begin
      newValue = oldValue;
      for (int i = 0; i < BYTES; i++)
      begin
         if (lane == 2'(i))
         begin
            newValue[8*i +: 8] = data;
         end
      end
   end
endmodule

// *** rtl/multibyte_register_byte_access.sv ***
// Purpose: Byte-addressed writes to atomic and non-atomic 32-bit fields
// Assumes: Byte writes arrive from logic on core_clk
// Notes: Each instance holds one atomic and one non-atomic field
`timescale 1ns/10ps
`include "mbra_defines.svh"
module multibyte_register_byte_access
#(
   parameter int INSTANCES = `MBRA_BLOCK_COUNT,
   parameter int BYTES = `MBRA_FIELD_BYTES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire mbra_pkg::byte_wr_t wrReq,
   input wire logic rdEn_n,
   output logic [7:0] rdData,
   output logic wrHit,
   output logic [INSTANCES*8*BYTES-1:0] atomicValue,
   output logic [INSTANCES*8*BYTES-1:0] plainValue,
   output logic [INSTANCES-1:0] atomicCommit
);
   localparam int FW = 8*BYTES;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic mbra_pkg::decode_t decodeAddr(input logic [7:0] a);
      mbra_pkg::decode_t d;
      logic [7:0] rel;
      logic [7:0] ofs;
      d = '0;
      for (int n = 0; n < INSTANCES; n++)
      begin
         rel = a - (`MBRA_BLOCK_BASE + 8'(n) * `MBRA_BLOCK_STRIDE);
         if (rel < `MBRA_BLOCK_STRIDE)
         begin
            ofs = rel & ~8'(BYTES - 1);
            d.hit = 1'b1;
            d.inst = 1'(n);
            d.atomic = (ofs == `MBRA_ATOMIC_OFS);
            d.lane = rel[1:0];
         end
      end
      return d;
   endfunction

   mbra_pkg::decode_t wrDec;
   mbra_pkg::decode_t rdDec;
   logic [FW-1:0] curPlain;
   logic [FW-1:0] curShadow;
   logic [FW-1:0] mergedShadow;
   logic [FW-1:0] mergedPlain;
   logic [FW-1:0] shadow [INSTANCES];
   logic isTop;

   always_comb
   begin
      wrDec = decodeAddr(wrReq.addr);
      rdDec = decodeAddr(wrReq.addr);
      curPlain = plainValue[wrDec.inst*FW +: FW];
      curShadow = shadow[wrDec.inst];
      isTop = (wrDec.lane == 2'(BYTES - 1));
   end

   field_byte_merge #(.BYTES(BYTES)) mergeShadow
   (
      .oldValue(curShadow),
      .lane(wrDec.lane),
      .data(wrReq.data),
      .newValue(mergedShadow)
   );

   field_byte_merge #(.BYTES(BYTES)) mergePlain
   (
      .oldValue(curPlain),
      .lane(wrDec.lane),
      .data(wrReq.data),
      .newValue(mergedPlain)
   );

   // ----------------------------------------
   // Atomic fields: buffer then commit
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int n = 0; n < INSTANCES; n++)
         begin
            shadow[n] <= `MBRA_RESET_VALUE;
         end
         atomicValue <= '0;
         atomicCommit <= '0;
      end
      else
      begin
         atomicCommit <= '0;
         if (wrReq.valid && wrDec.hit && wrDec.atomic)
         begin
            // Shadow keeps old bytes so a partial rewrite still commits whole
            shadow[wrDec.inst] <= mergedShadow;
            if (isTop)
            begin
               atomicValue[wrDec.inst*FW +: FW] <= mergedShadow;
               atomicCommit[wrDec.inst] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Non-atomic fields: apply per byte
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         plainValue <= '0;
      end
      else if (wrReq.valid && wrDec.hit && !wrDec.atomic)
      begin
         plainValue[wrDec.inst*FW +: FW] <= mergedPlain;
      end
   end

   // ----------------------------------------
   // Read back and hit flag
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rdData <= 8'h00;
         wrHit <= 1'b0;
      end
      else
      begin
         wrHit <= wrReq.valid && wrDec.hit;
         if (!rdEn_n)
         begin
            // Atomic reads show the applied value, not the pending shadow
            if (!rdDec.hit)
               rdData <= 8'h00;
            else if (rdDec.atomic)
               rdData <= atomicValue[rdDec.inst*FW + 8*rdDec.lane +: 8];
            else
               rdData <= plainValue[rdDec.inst*FW + 8*rdDec.lane +: 8];
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence topWrite(int n);
      wrReq.valid && wrDec.hit && wrDec.atomic && isTop && wrDec.inst == 1'(n);
   endsequence

   sequence lowerWrite;
      wrReq.valid && wrDec.hit && wrDec.atomic && !isTop;
   endsequence

   sequence plainWrite;
      wrReq.valid && wrDec.hit && !wrDec.atomic;
   endsequence

   AST_LOWER_HELD: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && wrDec.hit && wrDec.atomic && !isTop)
      |=> $stable(atomicValue))
      else $error("atomic value moved on a lower byte write");

   AST_TOP_COMMITS: assert property (@(posedge core_clk) disable iff (rst)
      topWrite(0) |=> atomicCommit[0] && atomicValue[FW-1:FW-8] == $past(wrReq.data))
      else $error("top byte write did not commit");

   AST_COMMIT_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
      atomicCommit[0]
      |-> $past(wrReq.valid && wrDec.hit && wrDec.atomic && isTop && wrDec.inst == 1'b0))
      else $error("commit without top byte write");

   AST_PLAIN_NOW: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && wrDec.hit && !wrDec.atomic && wrDec.inst == 1'b0 && wrDec.lane == 2'd0)
      |=> plainValue[7:0] == $past(wrReq.data))
      else $error("non-atomic byte not applied");

   AST_INST1_BASE: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && wrReq.addr == 8'(`MBRA_BLOCK_BASE + `MBRA_BLOCK_STRIDE))
      |-> wrDec.hit && wrDec.inst == 1'b1 && wrDec.lane == 2'h0)
      else $error("instance 1 base misdecoded");

   AST_BYTE_ORDER: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && wrReq.addr == 8'(`MBRA_BLOCK_BASE + `MBRA_PLAIN_OFS + 8'h01))
      |=> plainValue[15:8] == $past(wrReq.data))
      else $error("byte lane order wrong");

   AST_MISS_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && !wrDec.hit) |=> $stable(plainValue) && $stable(atomicValue) && !wrHit)
      else $error("unmapped write had effect");

   AST_READ_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      rdEn_n |=> $stable(rdData))
      else $error("read data changed while read deasserted");

   AST_INST1_COMMIT: assert property (@(posedge core_clk) disable iff (rst)
      topWrite(1) |=> atomicCommit[1] && atomicValue[2*FW-1 -: 8] == $past(wrReq.data))
      else $error("instance 1 top byte write did not commit");

   AST_COMMIT_WHOLE: assert property (@(posedge core_clk) disable iff (rst)
      topWrite(0) |=> atomicValue[FW-9:0] == $past(curShadow[FW-9:0]))
      else $error("commit lost buffered lower bytes");

   AST_LOWER_NO_COMMIT: assert property (@(posedge core_clk) disable iff (rst)
      lowerWrite |=> !(|atomicCommit))
      else $error("lower byte write raised a commit");

   AST_PLAIN_SPARES_ATOMIC: assert property (@(posedge core_clk) disable iff (rst)
      plainWrite |=> $stable(atomicValue) && !(|atomicCommit))
      else $error("non-atomic write touched an atomic field");

   AST_HIT_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      (wrReq.valid && wrDec.hit) |=> wrHit)
      else $error("mapped write gave no hit flag");

   AST_READ_MISS_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      (!rdEn_n && !rdDec.hit) |=> rdData == 8'h00)
      else $error("unmapped read returned data");

   // Pending shadow bytes must never leak onto the read port
   AST_ATOMIC_READ: assert property (@(posedge core_clk) disable iff (rst)
      (!rdEn_n && rdDec.hit && rdDec.atomic && rdDec.inst == 1'b1 && rdDec.lane == 2'h0)
      |=> rdData == $past(atomicValue[FW+7:FW]))
      else $error("atomic read did not show the applied value");
endmodule

// *** bench/host_model.sv ***
// Purpose: Host that writes and reads field bytes one at a time
// Assumes: Design takes requests on the rising edge of core_clk
// Notes: Released lines show the inverse of their last value
`timescale 1ns/10ps
module host_model
(
   input wire logic core_clk,
   output mbra_pkg::byte_wr_t wrReq,
   output logic rdEn_n
);
   initial
   begin
      wrReq = 17'h00000;
      rdEn_n = 1'b1;
   end
   task write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      wrReq = {1'b1, a, d};
      @(posedge core_clk);
      #1;
      wrReq = {1'b0, ~a, ~d};
   endtask
   // Read enable is active low, asserted at 0
   task read(input logic [7:0] a);
      @(posedge core_clk);
      #1;
      rdEn_n = 1'b0;
      wrReq.addr = a;
      @(posedge core_clk);
      #1;
      rdEn_n = 1'b1;
      wrReq.addr = ~a;
   endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for byte writes to multi-byte fields
// Assumes: Two instances, 4-byte fields, host_model on the far side
// Notes: Expected values kept by a byte-lane model in the bench
`timescale 1ns/10ps
`include "mbra_defines.svh"
module testbench;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic h;} row_t;
   logic core_clk, rst, rdEn_n, wrHit;
   mbra_pkg::byte_wr_t wrReq;
   logic [7:0] rdData;
   logic [63:0] atomicValue, plainValue, expAtom, expPlain, shadow;
   logic [1:0] atomicCommit, expCommit;
   int fail_count = 0;
   int samples_checked = 0;
   row_t rows [12] = '{'{8'h14, 8'hA1, 1'b1}, '{8'h15, 8'hB2, 1'b1}, '{8'h16, 8'hC3, 1'b1},
      '{8'h17, 8'hD4, 1'b1}, '{8'h1F, 8'hE5, 1'b1}, '{8'h1C, 8'h96, 1'b1},
      '{8'h10, 8'h11, 1'b1}, '{8'h11, 8'h22, 1'b1}, '{8'h12, 8'h33, 1'b1},
      '{8'h13, 8'h44, 1'b1}, '{8'h20, 8'h77, 1'b0}, '{8'h0F, 8'h55, 1'b0}};
   host_model u_host(.core_clk(core_clk), .wrReq(wrReq), .rdEn_n(rdEn_n));
   multibyte_register_byte_access #(.INSTANCES(2), .BYTES(4)) u_dut(.core_clk(core_clk),
      .rst(rst), .wrReq(wrReq), .rdEn_n(rdEn_n), .rdData(rdData), .wrHit(wrHit),
      .atomicValue(atomicValue), .plainValue(plainValue), .atomicCommit(atomicCommit));
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task cmp(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_chk(input logic [7:0] a, input logic [7:0] d, input logic h);
      logic [7:0] loc;
      int i;
      loc = (a - `MBRA_BLOCK_BASE) % `MBRA_BLOCK_STRIDE;
      i = (a - `MBRA_BLOCK_BASE) / `MBRA_BLOCK_STRIDE;
      expCommit = 2'h0;
      u_host.write(a, d);
      if (h && loc >= `MBRA_PLAIN_OFS)
         expPlain[i*32 + loc[1:0]*8 +: 8] = d;
      else if (h)
      begin
         shadow[i*32 + loc[1:0]*8 +: 8] = d;
         if (loc[1:0] == 2'h3)
         begin
            expAtom[i*32 +: 32] = shadow[i*32 +: 32];
            expCommit[i] = 1'b1;
         end
      end
      cmp(wrHit, h);
      cmp(plainValue, expPlain);
      cmp(atomicValue, expAtom);
      cmp(atomicCommit, expCommit);
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_host.read(a);
      cmp(rdData, exp);
   endtask
   task zero_chk;
      {expAtom, expPlain, shadow} = '0;
      cmp(atomicValue, 64'h0);
      cmp(plainValue, 64'h0);
      cmp({wrHit, atomicCommit}, 64'h0);
   endtask
   task report_and_stop;
      $display("checked=%0d failed=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      rst = 1'b0;
      zero_chk();
      $display("reset test done");
      foreach (rows[k])
         wr_chk(rows[k].a, rows[k].d, rows[k].h);
      $display("row tests done");
      rd_chk(8'h16, 8'hC3);
      rd_chk(8'h13, 8'h44);
      rd_chk(8'h30, 8'h00);
      // Shadow bytes must stay invisible to reads
      wr_chk(8'h18, 8'h5C, 1'b1);
      wr_chk(8'h19, 8'h6D, 1'b1);
      rd_chk(8'h18, 8'h00);
      $display("read tests done");
      // Reset must drop the instance 1 shadow bytes still pending from the 0x18 and 0x19 writes
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      zero_chk();
      wr_chk(8'h1B, 8'h5A, 1'b1);
      $display("mid-run reset test done");
      report_and_stop();
   end
   initial
   begin
      #20000;
      fail_count++;
      report_and_stop();
   end
endmodule
